// >>> src/pdt_timer.sv
// Prescaled 8-bit down-counter timer with APB register slave, pin unit and interrupt
//
// Contract
// R01: Prescaler register at index D2h resets to 7Fh, bit 7 reads zero.
// R02: Counter register at index D3h, read/write, resets to FFh.
// R03: Control register at D4h resets 00h: flag, enable, direction, data, run, select.
// R04: Underflow flag rises when the counter goes from 00h to FFh.
// R05: Software clears the underflow flag by writing zero; hardware never clears it.
// R06: Timer request is high exactly when flag and interrupt enable are both one.
// R07: Direction zero makes the pin an input; one drives it push-pull.
// R08: Output mode latches data bit onto pin at flag rise; input mode picks gated/event.
// R09: Run bit zero holds prescaler at 7Fh and freezes counter; one lets both count.
// R10: Divider select gives division by two to the power of the field.
// R11: Timer request also serves as wake-up from wait and stop.
// R12: Counter decrements per divided tick, reloads FFh; prescaler reloads 7Fh after zero.
// R13: Source: gated divide-by-12 when pin high, pin rising edges, or divide-by-12.
// R14: Counter write beats a coincident underflow; no flag until next real underflow. The code sets the flag at once when zero is written.
// R15: Pin is synchronised, then edges or levels are detected before use.
// R16: Counter advances once per two-to-the-select prescaler input ticks.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
module pdt_timer #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // APB slave
  input wire pdt_pkg::pdt_apb_req_t apb_req,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // Timer pin, split into input, output and output enable
  input wire logic timer_pin_i,
  output logic timer_pin_o,
  output logic timer_pin_oe,
  // Requests to the core
  output logic timer_irq,
  output logic wake_req,
  output logic irq
);

  pdt_pkg::pdt_state_t q;
  pdt_pkg::pdt_state_t d;

  // Index of the word addressed; upper address bits must be zero to hit
  function automatic logic [7:0] reg_index(input logic [11:0] addr);
    reg_index = addr[9:2];
  endfunction

  function automatic logic is_mapped(input logic [11:0] addr);
    logic [7:0] idx;
    idx = reg_index(addr);
    is_mapped = (addr[11:10] == 2'h0) && (addr[1:0] == 2'h0) &&
                (idx == pdt_pkg::IDX_PRESCALER || idx == pdt_pkg::IDX_COUNT ||
                 idx == pdt_pkg::IDX_CTRL || idx == pdt_pkg::IDX_IRQ_STATUS ||
                 idx == pdt_pkg::IDX_IRQ_MASK);
  endfunction

  // Low bits of the prescaler that must be zero for the selected tap
  function automatic logic [6:0] tap_mask(input logic [2:0] sel);
    tap_mask = 7'((8'h01 << sel) - 8'h01);
  endfunction

  function automatic logic [31:0] read_reg(input pdt_pkg::pdt_state_t s, input logic [7:0] idx);
    read_reg = 32'h0000_0000;
    unique case (idx)
      pdt_pkg::IDX_PRESCALER: read_reg = {25'h000_0000, s.presc}; // [R01]
      pdt_pkg::IDX_COUNT: read_reg = {24'h00_0000, s.count}; // [R02]
      pdt_pkg::IDX_CTRL: read_reg = {24'h00_0000, s.ctrl}; // [R03]
      pdt_pkg::IDX_IRQ_STATUS: read_reg = {30'h0000_0000, s.irq_status};
      pdt_pkg::IDX_IRQ_MASK: read_reg = {30'h0000_0000, s.irq_mask};
      default: read_reg = 32'h0000_0000;
    endcase
  endfunction

  logic div_tick;
  logic pin_rise;
  logic src_tick;
  logic cnt_tick;
  logic underflow;
  logic flag_set;
  logic wr;
  logic [7:0] wr_idx;
  logic out_mode;
  logic data_bit;
  logic run;
  logic [2:0] sel;

  always_comb begin
    d = q;
    out_mode = q.ctrl[pdt_pkg::CTRL_DIR_BIT];
    data_bit = q.ctrl[pdt_pkg::CTRL_DATA_BIT];
    run = q.ctrl[pdt_pkg::CTRL_RUN_BIT];
    sel = q.ctrl[pdt_pkg::CTRL_SEL_LSB +: pdt_pkg::CTRL_SEL_W];

    // Two-flop synchroniser, then a third flop for edge detection
    d.pin_meta = timer_pin_i; // [R15]
    d.pin_sync = q.pin_meta; // [R15]
    d.pin_prev = q.pin_sync;
    pin_rise = q.pin_sync & ~q.pin_prev; // [R15]

    // Internal divide-by-12 runs free so gated mode keeps its phase
    div_tick = (q.div_cnt == pdt_pkg::INT_DIV_LAST);
    if (div_tick) begin
      d.div_cnt = pdt_pkg::INT_DIV_RST;
    end else begin
      d.div_cnt = q.div_cnt + 4'h1;
    end

    // Prescaler source by mode
    if (out_mode) begin
      src_tick = div_tick; // [R13]
    end else if (data_bit) begin
      src_tick = div_tick & q.pin_sync; // [R13] [R08]
    end else begin
      src_tick = pin_rise; // [R13] [R08]
    end

    // Prescaler and tap
    cnt_tick = 1'b0;
    if (!run) begin
      d.presc = pdt_pkg::PRESC_RST; // [R09]
    end else if (src_tick) begin
      cnt_tick = ((q.presc & tap_mask(sel)) == 7'h00); // [R10] [R16]
      if (q.presc == 7'h00) begin
        d.presc = pdt_pkg::PRESC_RST; // [R12]
      end else begin
        d.presc = q.presc - 7'h01; // [R09]
      end
    end

    // Counter
    underflow = 1'b0;
    if (cnt_tick) begin
      if (q.count == 8'h00) begin
        d.count = pdt_pkg::COUNT_RST; // [R12]
        underflow = 1'b1; // [R04]
      end else begin
        d.count = q.count - 8'h01; // [R12]
      end
    end

    // Register writes take effect at the access edge
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite & q.pready & ~q.pslverr;
    wr_idx = reg_index(apb_req.paddr);
    flag_set = underflow;

    if (wr && wr_idx == pdt_pkg::IDX_COUNT) begin
      // A write wins over the decrement; writing zero marks the flag directly
      d.count = apb_req.pwdata[7:0]; // [R14]
      flag_set = (apb_req.pwdata[7:0] == 8'h00); // [R14]
    end

    // Direct prescaler load only while running; held at reset value otherwise
    if (wr && wr_idx == pdt_pkg::IDX_PRESCALER && run) begin
      d.presc = apb_req.pwdata[6:0]; // [R01]
    end

    if (wr && wr_idx == pdt_pkg::IDX_CTRL) begin
      // Hardware set beats a software clear in the same cycle
      d.ctrl = apb_req.pwdata[7:0]; // [R03]
      d.ctrl[pdt_pkg::CTRL_FLAG_BIT] = apb_req.pwdata[pdt_pkg::CTRL_FLAG_BIT] | flag_set; // [R05]
    end else if (flag_set) begin
      d.ctrl[pdt_pkg::CTRL_FLAG_BIT] = 1'b1; // [R04]
    end

    // Data bit is latched to the pin on the flag's rising edge
    if (d.ctrl[pdt_pkg::CTRL_FLAG_BIT] && !q.ctrl[pdt_pkg::CTRL_FLAG_BIT]) begin
      d.pin_out = d.ctrl[pdt_pkg::CTRL_DATA_BIT]; // [R08]
    end

    // Sticky event bits, write one to clear, set wins
    if (wr && wr_idx == pdt_pkg::IDX_IRQ_STATUS) begin
      d.irq_status = q.irq_status & ~apb_req.pwdata[1:0];
    end
    if (underflow || flag_set) begin
      d.irq_status[pdt_pkg::EVT_UNDERFLOW_BIT] = 1'b1;
    end
    if (pin_rise && !out_mode) begin
      d.irq_status[pdt_pkg::EVT_PIN_EDGE_BIT] = 1'b1;
    end
    if (wr && wr_idx == pdt_pkg::IDX_IRQ_MASK) begin
      d.irq_mask = apb_req.pwdata[1:0];
    end

    // Requests follow the next state so they line up with the flag
    d.timer_irq = d.ctrl[pdt_pkg::CTRL_FLAG_BIT] & d.ctrl[pdt_pkg::CTRL_IEN_BIT]; // [R06]
    d.wake = d.ctrl[pdt_pkg::CTRL_FLAG_BIT] & d.ctrl[pdt_pkg::CTRL_IEN_BIT]; // [R11]
    d.irq = |(d.irq_status & d.irq_mask);

    // APB: read data is captured in the setup cycle, one wait-free access cycle follows
    d.pready = apb_req.psel & ~apb_req.penable;
    d.pslverr = apb_req.psel & ~apb_req.penable & ~is_mapped(apb_req.paddr);
    if (apb_req.psel && !apb_req.penable && !apb_req.pwrite && is_mapped(apb_req.paddr)) begin
      d.prdata = read_reg(q, wr_idx);
    end else begin
      d.prdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q.pin_meta <= 1'b0;
      q.pin_sync <= 1'b0;
      q.pin_prev <= 1'b0;
      q.div_cnt <= pdt_pkg::INT_DIV_RST;
      q.presc <= pdt_pkg::PRESC_RST; // [R01]
      q.count <= pdt_pkg::COUNT_RST; // [R02]
      q.ctrl <= pdt_pkg::CTRL_RST; // [R03] [R07]
      q.irq_status <= pdt_pkg::IRQ_STATUS_RST;
      q.irq_mask <= pdt_pkg::IRQ_MASK_RST;
      q.pin_out <= 1'b0;
      q.timer_irq <= 1'b0;
      q.wake <= 1'b0;
      q.irq <= 1'b0;
      q.pready <= 1'b0;
      q.pslverr <= 1'b0;
      q.prdata <= 32'h0000_0000;
    end else begin
      q <= d;
    end
  end

  // Pin drives only in output mode; enable is a flop bit of the control register
  assign timer_pin_oe = q.ctrl[pdt_pkg::CTRL_DIR_BIT]; // [R07]
  assign timer_pin_o = q.pin_out; // [R08]
  assign timer_irq = q.timer_irq;
  assign wake_req = q.wake;
  assign irq = q.irq;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign prdata = q.prdata;

endmodule

// >>> common/pdt_pkg.sv
// Package: register map, field layout, reset values and state for the prescaled down-counter timer
package pdt_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PRESCALER = 8'hD2;
  localparam logic [7:0] IDX_COUNT = 8'hD3;
  localparam logic [7:0] IDX_CTRL = 8'hD4;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hD5;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hD6;

  // Reset values
  localparam logic [6:0] PRESC_RST = 7'h7F;
  localparam logic [7:0] COUNT_RST = 8'hFF;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] IRQ_STATUS_RST = 2'h0;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // Control register fields
  localparam int CTRL_FLAG_BIT = 7;
  localparam int CTRL_IEN_BIT = 6;
  localparam int CTRL_DIR_BIT = 5;
  localparam int CTRL_DATA_BIT = 4;
  localparam int CTRL_RUN_BIT = 3;
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_SEL_W = 3;

  // Event status / mask fields
  localparam int EVT_UNDERFLOW_BIT = 0;
  localparam int EVT_PIN_EDGE_BIT = 1;

  // Internal clock divided by 12 feeds the prescaler
  localparam int INT_DIV = 12;
  localparam logic [3:0] INT_DIV_LAST = 4'(INT_DIV - 1);
  localparam logic [3:0] INT_DIV_RST = 4'h0;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pdt_apb_req_t;

  // Whole state of the timer
  typedef struct packed {
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic [3:0] div_cnt;
    logic [6:0] presc;
    logic [7:0] count;
    logic [7:0] ctrl;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic pin_out;
    logic timer_irq;
    logic wake;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pdt_state_t;

endpackage

// >>> verif/pdt_timer_chk.sv
// Port-level assertions for the prescaled down-counter timer
`timescale 1ns/1ns
module pdt_timer_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register bus
  input wire pdt_pkg::pdt_apb_req_t apb_req,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // Pin and requests
  input wire logic timer_pin_i,
  input wire logic timer_pin_o,
  input wire logic timer_pin_oe,
  input wire logic timer_irq,
  input wire logic wake_req,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire logic acc_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;

  wake_same_a: assert property (wake_req == timer_irq) else $error("wake differs from request");
  pin_dir_a: assert property (!$stable(timer_pin_oe) |-> $past(acc_wr && apb_req.paddr == 12'h350))
    else $error("pin direction moved without control write");
  flag_hold_a: assert property ($fell(timer_irq) |-> $past(acc_wr && apb_req.paddr == 12'h350))
    else $error("timer request dropped without control write");
  irq_clear_a: assert property ($fell(irq) |-> $past(acc_wr && apb_req.paddr inside {12'h354, 12'h358}))
    else $error("event interrupt dropped without write");
  answer_a: assert property (apb_req.psel && !apb_req.penable |=> pready) else $error("no answer");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
  err_map_a: assert property (pready |-> pslverr == !(apb_req.paddr inside {[12'h348:12'h358]} &&
    apb_req.paddr[1:0] == 2'h0)) else $error("error response wrong");
  idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
  wide_zero_a: assert property (pready && !apb_req.pwrite |-> prdata[31:8] == 24'h0 &&
    !(apb_req.paddr == 12'h348 && prdata[7])) else $error("unused read bits set");
endmodule

bind pdt_timer pdt_timer_chk chk (.core_clk(core_clk), .rstn(rstn), .apb_req(apb_req), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .timer_pin_i(timer_pin_i), .timer_pin_o(timer_pin_o),
  .timer_pin_oe(timer_pin_oe), .timer_irq(timer_irq), .wake_req(wake_req), .irq(irq));

// >>> verif/pdt_timer_bench.sv
// Self-checking bench for the prescaled down-counter timer
`timescale 1ns/1ns
module pdt_timer_bench;
  localparam logic [11:0] A_PS = 12'h348, A_CT = 12'h34C, A_CR = 12'h350, A_ST = 12'h354, A_MK = 12'h358;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic pin = 1'b0;
  pdt_pkg::pdt_apb_req_t req = '0;
  logic pready, pslverr, tpo, tpoe, tirq, wake, irq, err;
  logic [31:0] prdata;
  logic [7:0] rd;
  int error_cnt = 0;
  int n_tests = 0;
  int i;

  always #4 core_clk = ~core_clk;

  pdt_timer dut (.core_clk(core_clk), .rstn(rstn), .apb_req(req), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .timer_pin_i(pin), .timer_pin_o(tpo), .timer_pin_oe(tpoe), .timer_irq(tirq),
    .wake_req(wake), .irq(irq));

  task automatic wrap_up;
    $display("Checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Two idle edges after each transfer let register effects reach the outputs
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
    @(posedge core_clk);
    req.penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge core_clk);
    if (k == 20) begin
      error_cnt++;
      wrap_up;
    end
    rd = prdata[7:0];
    err = pslverr;
    req <= '0;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, rd, e);
  endtask

  task automatic t_reset;
    rchk("presc", A_PS, 8'h7F);
    rchk("count", A_CT, 8'hFF);
    rchk("ctrl", A_CR, 8'h00);
    rchk("mask", A_MK, 8'h00);
    rchk("unmapped", 12'h35C, 8'h00);
    chk("unmapped_err", {7'h0, err}, 8'h01);
  endtask

  task automatic t_under;
    bus(1'b1, A_CT, 8'h01);
    bus(1'b1, A_CR, 8'h78);
    for (i = 0; i < 100 && tirq !== 1'b1; i++) @(posedge core_clk);
    chk("flag_seen", {7'h0, tirq}, 8'h01);
    chk("pin_out", {6'h0, tpoe, tpo}, 8'h03);
    chk("wake", {6'h0, wake, tirq}, 8'h03);
    rchk("reload", A_CT, 8'hFF);
    bus(1'b1, A_MK, 8'h01);
    chk("irq_set", {7'h0, irq}, 8'h01);
    bus(1'b1, A_ST, 8'h01);
    chk("irq_clr", {7'h0, irq}, 8'h00);
    chk("flag_kept", {7'h0, tirq}, 8'h01);
    bus(1'b1, A_CR, 8'h08);
    chk("flag_clr", {6'h0, tpoe, tirq}, 8'h00);
  endtask

  task automatic t_freeze;
    bus(1'b1, A_CR, 8'h00);
    rchk("psc_hold", A_PS, 8'h7F);
    bus(1'b1, A_CT, 8'h80);
    repeat (40) @(posedge core_clk);
    rchk("frozen", A_CT, 8'h80);
  endtask

  // Divide by 8: 35 or 36 prescaler steps in the wait both give four counter ticks
  task automatic t_div;
    bus(1'b1, A_CR, 8'h2B);
    repeat (425) @(posedge core_clk);
    rchk("div8", A_CT, 8'h7C);
  endtask

  task automatic t_event;
    bus(1'b1, A_CR, 8'h00);
    bus(1'b1, A_CT, 8'h10);
    bus(1'b1, A_CR, 8'h08);
    for (i = 0; i < 3; i++) begin
      pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      pin <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    rchk("events", A_CT, 8'h0D);
    rchk("edge_status", A_ST, 8'h02);
    bus(1'b1, A_CR, 8'h18);
    repeat (40) @(posedge core_clk);
    rchk("gate_low", A_CT, 8'h0D);
  endtask

  // Gated mode with the pin low gives no ticks, so loads are seen unchanged
  task automatic t_load;
    bus(1'b1, A_PS, 8'h25);
    rchk("psc_load", A_PS, 8'h25);
    bus(1'b1, A_CT, 8'h00);
    rchk("zero_flag", A_CR, 8'h98);
    chk("no_ien_req", {7'h0, tirq}, 8'h00);
    bus(1'b1, A_CR, 8'h00);
    rchk("psc_init", A_PS, 8'h7F);
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset;
    t_under;
    t_freeze;
    t_div;
    t_event;
    t_load;
    wrap_up;
  end
endmodule
